// ---- aofs_pkg.sv ----
// aofs_pkg: register map, field layout, reset values and carrier types for the
// sampler output formatter and serializer.
// assumes a 32-bit apb slave with one aligned word per register index.
package aofs_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam logic [3:0] AOFS_IDX_CTRL = 4'h1;
  localparam logic [3:0] AOFS_IDX_STREAM = 4'h2;
  localparam logic [3:0] AOFS_IDX_FRAMES = 4'h6;
  localparam logic [3:0] AOFS_IDX_CLK = 4'h7;
  localparam logic [3:0] AOFS_IDX_STATUS = 4'ha;

  // ==========================================================================
  // ctrl fields
  localparam int AOFS_CTRL_DRV_LSB = 0;
  localparam int AOFS_CTRL_FMT_LSB = 2;
  localparam int AOFS_CTRL_WIDTH_LSB = 4;
  localparam int AOFS_CTRL_QUAD_BIT = 7;
  // stream fields
  localparam int AOFS_SCFG_LANE_LSB = 0;
  localparam int AOFS_SCFG_EN_BIT = 2;
  localparam int AOFS_SCFG_TS_LSB = 4;
  // clk fields
  localparam int AOFS_CLK_L_LSB = 0;
  localparam int AOFS_CLK_M_LSB = 12;
  localparam int AOFS_CLK_BYP_BIT = 24;
  localparam int AOFS_CLK_SRC_BIT = 25;
  // status fields
  localparam int AOFS_STAT_ACTIVE_BIT = 4;
  localparam int AOFS_STAT_FRAMES_LSB = 16;

  // ==========================================================================
  // codes
  localparam logic [1:0] AOFS_DRV_CMOS = 2'h0;
  localparam logic [1:0] AOFS_FMT_UNSIGNED = 2'h0;
  localparam logic [1:0] AOFS_FMT_SIGNMAG = 2'h1;
  localparam logic [2:0] AOFS_W_ONE = 3'h0;
  localparam logic [2:0] AOFS_W_TWO = 3'h2;
  localparam logic [2:0] AOFS_W_THREE = 3'h4;
  localparam logic [1:0] AOFS_LANES_0 = 2'h0;
  localparam logic [1:0] AOFS_LANES_01 = 2'h1;
  localparam logic [1:0] AOFS_LANES_02 = 2'h2;
  localparam logic [1:0] AOFS_LANES_ALL = 2'h3;

  // ==========================================================================
  // reset values and limits
  localparam logic [1:0] AOFS_RST_DRV = AOFS_DRV_CMOS;
  localparam logic [1:0] AOFS_RST_FMT = AOFS_FMT_SIGNMAG;
  localparam logic [2:0] AOFS_RST_WIDTH = AOFS_W_TWO;
  localparam logic AOFS_RST_QUAD = 1'b1;
  localparam logic [1:0] AOFS_RST_LANES = AOFS_LANES_0;
  localparam logic AOFS_RST_STREAM_FRAME_COUNT_REG_EN = 1'b0;
  localparam logic [14:0] AOFS_RST_TS_PERIOD = 15'h0400;
  localparam logic [15:0] AOFS_RST_FRAMES = 16'h0000;
  localparam logic [11:0] AOFS_RST_L = 12'h001;
  localparam logic [11:0] AOFS_RST_M = 12'hffd;
  localparam logic AOFS_RST_BYP = 1'b0;
  localparam logic AOFS_RST_SRC = 1'b0;
  localparam logic [14:0] AOFS_TS_MIN = 15'h0080;
  localparam logic [14:0] AOFS_TS_MAX = 15'h4000;
  localparam logic [13:0] AOFS_DIV_BASE = 14'h1000;
  localparam logic [3:0] AOFS_SLICE_LAST = 4'hf;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic inphase_high_pin;
    logic inphase_low_pin;
    logic quad_high_pin;
    logic quad_low_pin;
  } aofs_pins_t;

  typedef struct packed {
    logic ser_data;
    logic slice_sync;
    logic time_sync;
    logic sample_tick;
  } aofs_stream_t;

  typedef struct packed {
    logic [1:0] output_driver_select;
    logic [1:0] code_format;
    logic [2:0] sample_width;
    logic quadrature_channel_enable;
    logic [1:0] stream_lane_select;
    logic stream_enable;
    logic [14:0] time_sync_period;
    logic [15:0] stream_frame_count_reg;
    logic [11:0] divider_low_count;
    logic [11:0] divider_modulus_count;
    logic frac_divider_bypass;
    logic sample_clock_source;
  } aofs_cfg_t;

  typedef struct packed {
    aofs_cfg_t cfg;
    logic [13:0] acc;
    logic tick;
    logic [14:0] ts_cnt;
    logic [3:0] samp_cnt;
    logic [3:0][15:0] hold;
    logic [3:0][15:0] shreg;
    logic active;
    logic [1:0] pos;
    logic [3:0] bitcnt;
    logic [15:0] frames;
    aofs_pins_t pins;
    logic analog_bypass;
    aofs_stream_t link;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aofs_state_t;

endpackage

// ---- aofs_formatter.sv ----
// aofs_formatter: sample code formatter, pin mapper, fractional sample clock
// divider and 16-bit slice serializer behind an apb register slave.
// assumes one clock pclk; sample and serial clocks are enables derived from it,
// and converter codes arrive synchronous to pclk.
//
// What this block does
// RL1 - driver 00 cmos, 01 reserved, 1x analog
// RL2 - format 00 unsigned, 01 signmag, 1x twos
// RL3 - reset default two bits, sign and magnitude
// RL4 - quad enable 0 i only; 3-bit i only
// RL5 - width 000 one, 010 two, 100 three
// RL6 - msb on high pin, lsb on low
// RL7 - three bits on i high, i low, q high
// RL8 - sign-magnitude: sign set for negative levels
// RL9 - unsigned and twos complement code tables
// RL10 - divider ratio l over 4096 minus m plus l
// RL11 - fraction alternates neighbouring integer ratios
// RL12 - bypass bit skips fractional divider
// RL13 - source bit picks reference or divided clock
// RL14 - lanes 0,1 in-phase; lanes 2,3 quadrature
// RL15 - lane select: 0, 0+1, 0+2, all
// RL16 - sixteen bits per lane in rotation
// RL17 - serial clock fast enough for lanes; not checked, a new slice mid-rotation restarts the serializer at lane 0
// RL18 - four 16-bit holding registers capture samples
// RL19 - slice end moves holding into shift registers
// RL20 - zeros after valid data until next slice
// RL21 - slice sync marks each valid slice
// RL22 - periodic time sync, 128 to 16384 samples
// RL23 - frame count register at index six
// RL24 - divider counts register at index seven
// RL25 - oldest sample first, one bit per clock
// RL26 - slice sync one cycle on first bit
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module aofs_formatter
  import aofs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_div_tick,
  input wire logic [2:0] adc_i_code,
  input wire logic [2:0] adc_q_code,
  output aofs_pins_t pins,
  output logic analog_bypass,
  output aofs_stream_t link
);

  // ==========================================================================
  // helpers
  // level index k: 0..7 stands for -7,-5,...,+7
  function automatic logic [2:0] fmt_code(input logic [2:0] k, input logic [1:0] fmt);
    logic [2:0] r;
    r = k;
    if (fmt[1]) begin
      r = {~k[2], k[1:0]}; // RL9
    end else if (fmt == AOFS_FMT_SIGNMAG) begin
      r = {~k[2], (k[2] ? k[1:0] : ~k[1:0])}; // RL8
    end
    return r;
  endfunction

  function automatic logic [1:0] lane_of(input logic [1:0] sel, input logic [1:0] p);
    logic [1:0] r;
    r = 2'h0;
    unique case (sel)
      AOFS_LANES_0: r = 2'h0;
      AOFS_LANES_01: r = p[0] ? 2'h1 : 2'h0;
      AOFS_LANES_02: r = p[0] ? 2'h2 : 2'h0;
      AOFS_LANES_ALL: r = p;
    endcase
    return r;
  endfunction

  function automatic logic [1:0] last_pos(input logic [1:0] sel);
    logic [1:0] r;
    r = 2'h0;
    unique case (sel)
      AOFS_LANES_0: r = 2'h0;
      AOFS_LANES_01, AOFS_LANES_02: r = 2'h1;
      AOFS_LANES_ALL: r = 2'h3;
    endcase
    return r;
  endfunction

  aofs_state_t st;
  aofs_state_t next_st;

  // ==========================================================================
  // combinational decode shared by next-state and checks
  logic base_tick;
  logic [13:0] div_sum;
  logic [13:0] div_n;
  logic three_bit;
  logic one_bit;
  logic [14:0] ts_eff;
  logic [2:0] ci;
  logic [2:0] cq;
  logic [3:0] lanes;
  logic [3:0] idx;
  logic hit;

  // clock source and divider terms
  assign base_tick = st.cfg.sample_clock_source | ref_div_tick; // RL13
  assign div_sum = st.acc + {2'h0, st.cfg.divider_low_count};
  assign div_n = 14'(AOFS_DIV_BASE - {2'h0, st.cfg.divider_modulus_count}
                 + {2'h0, st.cfg.divider_low_count}); // RL10
  // width decode; three bits only without quadrature, odd codes fall to two
  assign three_bit = (st.cfg.sample_width == AOFS_W_THREE)
                     && !st.cfg.quadrature_channel_enable; // RL4 RL5
  assign one_bit = (st.cfg.sample_width == AOFS_W_ONE); // RL5
  // time sync period clamped into its legal span
  assign ts_eff = (st.cfg.time_sync_period < AOFS_TS_MIN) ? AOFS_TS_MIN :
                  (st.cfg.time_sync_period > AOFS_TS_MAX) ? AOFS_TS_MAX :
                  st.cfg.time_sync_period; // RL22
  assign ci = fmt_code(adc_i_code, st.cfg.code_format); // RL2
  assign cq = fmt_code(adc_q_code, st.cfg.code_format); // RL2
  assign idx = paddr[5:2];
  assign hit = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
               && (idx == AOFS_IDX_CTRL || idx == AOFS_IDX_STREAM
               || idx == AOFS_IDX_FRAMES || idx == AOFS_IDX_CLK
               || idx == AOFS_IDX_STATUS);

  // lane bits: 0 i msb, 1 i lsb, 2 q msb, 3 q lsb
  always_comb begin
    lanes = 4'h0;
    if (three_bit) begin
      lanes = {1'b0, ci[0], ci[1], ci[2]}; // RL7
    end else begin
      lanes[0] = ci[2]; // RL6 RL14
      lanes[1] = one_bit ? 1'b0 : ci[1]; // RL6 RL14
      if (st.cfg.quadrature_channel_enable) begin
        lanes[2] = cq[2]; // RL4 RL14
        lanes[3] = one_bit ? 1'b0 : cq[1];
      end
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    logic [3:0][15:0] nhold;
    logic [1:0] ln;
    nhold = st.hold;
    ln = lane_of(st.cfg.stream_lane_select, st.pos);
    next_st = st;
    next_st.link.slice_sync = 1'b0;
    next_st.link.time_sync = 1'b0;
    next_st.link.ser_data = 1'b0; // RL20
    next_st.pready = 1'b0;
    next_st.analog_bypass = st.cfg.output_driver_select[1]; // RL1

    // fractional divider: accumulate l, emit when the modulus is passed
    next_st.tick = 1'b0;
    if (st.cfg.frac_divider_bypass) begin
      next_st.tick = base_tick; // RL12
    end else if (base_tick && st.cfg.divider_low_count != 12'h000) begin
      if (div_sum >= div_n) begin
        next_st.tick = 1'b1; // RL11
        next_st.acc = 14'(div_sum - div_n);
      end else begin
        next_st.acc = div_sum;
      end
    end
    next_st.link.sample_tick = next_st.tick;

    // serial stream, one bit per clock, oldest sample first
    if (st.active) begin
      next_st.link.ser_data = st.shreg[ln][st.bitcnt]; // RL16 RL25
      next_st.link.slice_sync = (st.bitcnt == 4'h0); // RL21 RL26
      next_st.bitcnt = 4'(st.bitcnt + 4'h1);
      if (st.bitcnt == AOFS_SLICE_LAST) begin
        if (st.pos == last_pos(st.cfg.stream_lane_select)) begin
          next_st.active = 1'b0; // RL20
          next_st.pos = 2'h0;
        end else begin
          next_st.pos = 2'(st.pos + 2'h1); // RL15 RL16
        end
      end
    end

    // sample capture on each sample clock
    if (st.tick) begin
      nhold[0][st.samp_cnt] = lanes[0]; // RL18
      nhold[1][st.samp_cnt] = lanes[1];
      nhold[2][st.samp_cnt] = lanes[2];
      nhold[3][st.samp_cnt] = lanes[3];
      next_st.hold = nhold;
      next_st.samp_cnt = 4'(st.samp_cnt + 4'h1);
      if (st.cfg.output_driver_select == AOFS_DRV_CMOS) begin
        next_st.pins = {lanes[0], lanes[1], lanes[2], lanes[3]}; // RL1 RL6
      end else begin
        next_st.pins = '0; // RL1
      end
      // periodic time marker
      if (st.ts_cnt >= 15'(ts_eff - 15'h0001)) begin
        next_st.ts_cnt = 15'h0000;
        next_st.link.time_sync = 1'b1; // RL22
      end else begin
        next_st.ts_cnt = 15'(st.ts_cnt + 15'h0001);
      end
      // slice complete: hand the set to the shifters
      if (st.samp_cnt == AOFS_SLICE_LAST) begin
        next_st.shreg = nhold; // RL19
        if (st.cfg.stream_enable && (st.cfg.stream_frame_count_reg == 16'h0000
            || st.frames < st.cfg.stream_frame_count_reg)) begin
          next_st.active = 1'b1; // RL19
          next_st.pos = 2'h0;
          next_st.bitcnt = 4'h0;
          next_st.frames = 16'(st.frames + 16'h0001); // RL23
        end
      end
    end

    // apb: answer in the second access cycle, writes land on that edge
    if (psel && penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = 32'h0;
      if (hit && !pwrite) begin
        unique case (idx)
          AOFS_IDX_CTRL: begin
            next_st.prdata[AOFS_CTRL_DRV_LSB +: 2] = st.cfg.output_driver_select;
            next_st.prdata[AOFS_CTRL_FMT_LSB +: 2] = st.cfg.code_format;
            next_st.prdata[AOFS_CTRL_WIDTH_LSB +: 3] = st.cfg.sample_width;
            next_st.prdata[AOFS_CTRL_QUAD_BIT] = st.cfg.quadrature_channel_enable;
          end
          AOFS_IDX_STREAM: begin
            next_st.prdata[AOFS_SCFG_LANE_LSB +: 2] = st.cfg.stream_lane_select;
            next_st.prdata[AOFS_SCFG_EN_BIT] = st.cfg.stream_enable;
            next_st.prdata[AOFS_SCFG_TS_LSB +: 15] = st.cfg.time_sync_period;
          end
          AOFS_IDX_FRAMES: next_st.prdata[15:0] = st.cfg.stream_frame_count_reg;
          AOFS_IDX_CLK: begin
            next_st.prdata[AOFS_CLK_L_LSB +: 12] = st.cfg.divider_low_count;
            next_st.prdata[AOFS_CLK_M_LSB +: 12] = st.cfg.divider_modulus_count;
            next_st.prdata[AOFS_CLK_BYP_BIT] = st.cfg.frac_divider_bypass;
            next_st.prdata[AOFS_CLK_SRC_BIT] = st.cfg.sample_clock_source;
          end
          default: begin
            next_st.prdata[3:0] = st.samp_cnt;
            next_st.prdata[AOFS_STAT_ACTIVE_BIT] = st.active;
            next_st.prdata[AOFS_STAT_FRAMES_LSB +: 16] = st.frames;
          end
        endcase
      end
    end
    if (psel && penable && st.pready && pwrite && hit) begin
      unique case (idx)
        AOFS_IDX_CTRL: begin
          next_st.cfg.output_driver_select = pwdata[AOFS_CTRL_DRV_LSB +: 2];
          next_st.cfg.code_format = pwdata[AOFS_CTRL_FMT_LSB +: 2];
          next_st.cfg.sample_width = pwdata[AOFS_CTRL_WIDTH_LSB +: 3];
          next_st.cfg.quadrature_channel_enable = pwdata[AOFS_CTRL_QUAD_BIT];
        end
        AOFS_IDX_STREAM: begin
          next_st.cfg.stream_lane_select = pwdata[AOFS_SCFG_LANE_LSB +: 2];
          next_st.cfg.stream_enable = pwdata[AOFS_SCFG_EN_BIT];
          next_st.cfg.time_sync_period = pwdata[AOFS_SCFG_TS_LSB +: 15];
        end
        AOFS_IDX_FRAMES: begin
          next_st.cfg.stream_frame_count_reg = pwdata[15:0]; // RL23
          next_st.frames = 16'h0000;
        end
        AOFS_IDX_CLK: begin
          next_st.cfg.divider_low_count = pwdata[AOFS_CLK_L_LSB +: 12]; // RL24
          next_st.cfg.divider_modulus_count = pwdata[AOFS_CLK_M_LSB +: 12];
          next_st.cfg.frac_divider_bypass = pwdata[AOFS_CLK_BYP_BIT];
          next_st.cfg.sample_clock_source = pwdata[AOFS_CLK_SRC_BIT];
          next_st.acc = 14'h0000;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // state register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.cfg.output_driver_select <= AOFS_RST_DRV;
      st.cfg.code_format <= AOFS_RST_FMT; // RL3
      st.cfg.sample_width <= AOFS_RST_WIDTH; // RL3
      st.cfg.quadrature_channel_enable <= AOFS_RST_QUAD;
      st.cfg.stream_lane_select <= AOFS_RST_LANES;
      st.cfg.stream_enable <= AOFS_RST_STREAM_FRAME_COUNT_REG_EN;
      st.cfg.time_sync_period <= AOFS_RST_TS_PERIOD;
      st.cfg.stream_frame_count_reg <= AOFS_RST_FRAMES;
      st.cfg.divider_low_count <= AOFS_RST_L;
      st.cfg.divider_modulus_count <= AOFS_RST_M;
      st.cfg.frac_divider_bypass <= AOFS_RST_BYP;
      st.cfg.sample_clock_source <= AOFS_RST_SRC;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pins = st.pins;
  assign analog_bypass = st.analog_bypass;
  assign link = st.link;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_drv_off_pins: assert property (ce && st.tick && st.cfg.output_driver_select != 2'h0
    |=> st.pins == '0) else $error("pins driven while driver not cmos"); // RL1
  a_bypass_flag: assert property (ce && st.cfg.output_driver_select[1] |=> analog_bypass)
    else $error("analog bypass flag missing"); // RL1
  a_signmag_sign: assert property (ce && st.tick && st.cfg.output_driver_select == 2'h0
    && st.cfg.code_format == AOFS_FMT_SIGNMAG && st.cfg.quadrature_channel_enable
    |=> pins.inphase_high_pin == !$past(adc_i_code[2]))
    else $error("sign bit wrong"); // RL8
  a_three_bit_map: assert property (ce && st.tick && st.cfg.output_driver_select == 2'h0
    && st.cfg.code_format == AOFS_FMT_UNSIGNED && three_bit
    |=> {pins.inphase_high_pin, pins.inphase_low_pin, pins.quad_high_pin}
        == $past(adc_i_code)) else $error("three bit pin map wrong"); // RL7
  a_sync_one_cycle: assert property (ce && link.slice_sync |=> !link.slice_sync)
    else $error("slice sync longer than one cycle"); // RL26
  a_idle_zero: assert property (ce && !st.active |=> !link.ser_data)
    else $error("serial data not zero while idle"); // RL20
  a_time_sync: assert property (ce && st.tick && st.ts_cnt == 15'(ts_eff - 15'h0001)
    |=> link.time_sync) else $error("time sync missed"); // RL22
  a_bypass_tick: assert property (ce && st.cfg.frac_divider_bypass
    && st.cfg.sample_clock_source |=> st.tick) else $error("bypass tick missing"); // RL12
  a_frac_tick: assert property (ce && !st.cfg.frac_divider_bypass && base_tick
    && st.cfg.divider_low_count != 12'h000 && div_sum >= div_n |=> st.tick)
    else $error("fractional tick missing"); // RL10
  a_slice_load: assert property (ce && st.tick && st.samp_cnt == 4'hf
    && st.cfg.stream_enable && st.cfg.stream_frame_count_reg == 16'h0000
    |=> st.active && st.bitcnt == 4'h0 && st.pos == 2'h0)
    else $error("slice not loaded"); // RL19
  a_lane_rotate: assert property (ce && st.active && st.bitcnt == 4'hf && st.pos == 2'h0
    && st.cfg.stream_lane_select != AOFS_LANES_0 |=> st.active && st.pos == 2'h1)
    else $error("lane rotation wrong"); // RL16

  c_slice_sync: cover property (link.slice_sync);
  c_time_sync: cover property (link.time_sync);
  c_four_lanes: cover property (st.active && st.pos == 2'h3);
  c_apb_error: cover property (pready && pslverr);

endmodule

// ---- aofs_dsp_model.sv ----
// aofs_dsp_model: far-end receiver that collects the serial sample stream.
// assumes the serial clock is pclk and that link fields are registered.
`timescale 1ns/100ps
module aofs_dsp_model
  import aofs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire aofs_stream_t link
);
  // ==========================================================================
  // slice capture
  logic [15:0] slices[$];
  logic [15:0] word;
  int left;
  int idle_ones;
  int sync_mid;

  // gathers 16 bits starting in the sync cycle, oldest bit into bit 0; counts stray ones
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slices.delete();
      left = 0;
      idle_ones = 0;
      sync_mid = 0;
    end else begin
      if (link.slice_sync && left != 0) sync_mid++;
      if (link.slice_sync) left = 16;
      if (left > 0) begin
        word[16 - left] = link.ser_data;
        left--;
        if (left == 0) slices.push_back(word);
      end else if (link.ser_data) begin
        idle_ones++;
      end
    end
  end
endmodule

// ---- tb_adc_output_formatter_serializer.sv ----
// tb_adc_output_formatter_serializer: self-checking bench for aofs_formatter.
// assumes a 125 MHz pclk, apb register access, and the stream receiver model.
`timescale 1ns/100ps
module tb_adc_output_formatter_serializer
  import aofs_pkg::*;
;
  // ==========================================================================
  // signals
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic ref_div_tick = 0, pready, pslverr, analog_bypass, ref_en = 0, auto_codes = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [2:0] adc_i_code = '0, adc_q_code = '0;
  logic [1:0] rdiv = '0;
  logic [5:0] samp[$];
  aofs_pins_t pins;
  aofs_stream_t link;
  int miscompares = 0, cmp_count = 0, cyc = 0;
  localparam logic [11:0] A_CTRL = {6'h0, AOFS_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_SCFG = {6'h0, AOFS_IDX_STREAM, 2'h0};
  localparam logic [11:0] A_FRM = {6'h0, AOFS_IDX_FRAMES, 2'h0};
  localparam logic [11:0] A_CLK = {6'h0, AOFS_IDX_CLK, 2'h0};

  aofs_formatter aofs_formatter_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_div_tick(ref_div_tick),
    .adc_i_code(adc_i_code), .adc_q_code(adc_q_code), .pins(pins),
    .analog_bypass(analog_bypass), .link(link));
  aofs_dsp_model aofs_dsp_model_i (.pclk(pclk), .presetn(presetn), .link(link));

  // ==========================================================================
  // clock, hang guard, reference ticks and code stepping
  always #4 pclk = ~pclk;

  // cuts a hung run short
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // reference tick every third cycle; record sampled codes, step them per sample
  always @(posedge pclk) begin
    rdiv <= (rdiv == 2'h2) ? 2'h0 : rdiv + 2'h1;
    ref_div_tick <= ref_en && rdiv == 2'h0;
    if (!presetn) samp.delete();
    else if (link.sample_tick === 1'b1) begin
      samp.push_back({adc_i_code, adc_q_code});
      if (auto_codes) begin
        adc_i_code <= adc_i_code + 3'h1;
        adc_q_code <= adc_q_code + 3'h3;
      end
    end
  end

  // ==========================================================================
  // helpers
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("apb wait", 32'h2, n);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp, r);
    chk({what, " err"}, {31'h0, eerr}, {31'h0, e});
  endtask

  // three-bit code of level index k in each format
  function automatic logic [2:0] code3(input logic [1:0] f, input logic [2:0] k);
    if (f == 2'h0) return k;
    if (f == 2'h1) return {k < 3'h4, k >= 3'h4 ? k[1:0] : ~k[1:0]};
    return {~k[2], k[1:0]};
  endfunction

  // pin levels {i high, i low, q high, q low} for a width and channel setting
  function automatic logic [3:0] exp_pins(input logic [1:0] f, input logic [2:0] w,
                                          input logic qe, input logic [2:0] i,
                                          input logic [2:0] q);
    logic [2:0] ci;
    logic [2:0] cq;
    ci = code3(f, i);
    cq = code3(f, q);
    if (w == AOFS_W_THREE && !qe) return {ci, 1'b0};
    if (w == AOFS_W_ONE) return {ci[2], 1'b0, cq[2] & qe, 1'b0};
    return {ci[2:1], cq[2:1] & {2{qe}}};
  endfunction

  task automatic measure(input int cycles, output int n, output int lo, output int hi);
    int gap = 0;
    n = 0;
    lo = 1000;
    hi = 0;
    repeat (cycles) begin
      @(posedge pclk);
      gap++;
      if (link.sample_tick === 1'b1) begin
        if (n > 0 && gap < lo) lo = gap;
        if (n > 0 && gap > hi) hi = gap;
        n++;
        gap = 0;
      end
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs();
    rchk("ctrl", A_CTRL, 32'h0000_00a4, 1'b0);
    rchk("clk", A_CLK, 32'h00ff_d001, 1'b0);
    rchk("stream", A_SCFG, 32'h0000_4000, 1'b0);
    rchk("unmapped", 12'h030, 32'h0, 1'b1);
    wr(A_FRM, 32'h3);
    rchk("frames", A_FRM, 32'h3, 1'b0);
    wr(A_SCFG, 32'h100);
    rchk("ts low", A_SCFG, 32'h100, 1'b0);
    wr(A_SCFG, 32'h7fff0);
    rchk("ts high", A_SCFG, 32'h7fff0, 1'b0);
    wr(A_FRM, 32'h0);
  endtask

  task automatic t_format();
    int f, wi, qe, k, d;
    logic [2:0] w;
    wr(A_CLK, 32'h03ff_d001);
    for (f = 0; f < 4; f++) for (wi = 0; wi < 3; wi++) for (qe = 0; qe < 2; qe++) begin
      w = 3'(wi * 2);
      wr(A_CTRL, {24'h0, qe[0], w, f[1:0], 2'h0});
      for (k = 0; k < 8; k++) begin
        @(posedge pclk);
        adc_i_code <= k[2:0];
        adc_q_code <= 3'h7 - k[2:0];
        repeat (4) @(posedge pclk);
        chk("pins", 32'(exp_pins(f[1:0], w, qe[0], k[2:0], 3'h7 - k[2:0])), 32'(pins));
      end
    end
    // a low clock enable must hold the pins against a new code
    ce <= 1'b0;
    adc_i_code <= 3'h0;
    repeat (4) @(posedge pclk);
    chk("frozen pins", 32'(exp_pins(2'h3, 3'h4, 1'b1, 3'h7, 3'h0)), 32'(pins));
    ce <= 1'b1;
    adc_i_code <= 3'h7;
    for (d = 0; d < 4; d++) begin
      wr(A_CTRL, {24'h0, 6'h29, d[1:0]});
      repeat (4) @(posedge pclk);
      chk("driver pins", d == 0 ? 32'(exp_pins(2'h1, 3'h2, 1'b1, 3'h7, 3'h0)) : 0, 32'(pins));
      chk("analog", {31'h0, d[1]}, {31'h0, analog_bypass});
    end
  endtask

  task automatic t_divider();
    int n, lo, hi;
    wr(A_CLK, 32'h02ff_9002);
    repeat (20) @(posedge pclk);
    measure(900, n, lo, hi);
    chk("ratio", 200, n);
    chk("gap min", 4, lo);
    chk("gap max", 5, hi);
    ref_en <= 1'b1;
    wr(A_CLK, 32'h01ff_9002);
    repeat (20) @(posedge pclk);
    measure(900, n, lo, hi);
    chk("bypass", 300, n);
    chk("bypass gap", 3, hi);
    wr(A_CLK, 32'h00ff_9002);
    repeat (20) @(posedge pclk);
    measure(2700, n, lo, hi);
    chk("ref ratio", 200, n);
    ref_en <= 1'b0;
    repeat (20) @(posedge pclk);
    measure(300, n, lo, hi);
    chk("no ref", 0, n);
  endtask

  task automatic t_stream();
    int sel, nl, j, b, lane, n;
    logic [15:0] e;
    logic [5:0] s;
    logic [3:0] p;
    auto_codes <= 1'b1;
    for (sel = 0; sel < 4; sel++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      nl = (sel == 3) ? 4 : (sel == 0 ? 1 : 2);
      wr(A_SCFG, 32'h804 | sel);
      // five cycles a sample leaves the serial side room for four lanes
      wr(A_CLK, 32'h02ff_c001);
      n = 0;
      while (aofs_dsp_model_i.slices.size() < 2 * nl && n < 1000) begin
        @(posedge pclk);
        n++;
      end
      for (j = 0; j < 2 * nl; j++) begin
        lane = (sel == 2 && j % 2 == 1) ? 2 : j % nl;
        for (b = 0; b < 16; b++) begin
          s = samp[(j / nl) * 16 + b];
          p = exp_pins(2'h1, 3'h2, 1'b1, s[5:3], s[2:0]);
          e[b] = p[3 - lane];
        end
        chk("slice", {16'h0, e}, {16'h0, aofs_dsp_model_i.slices[j]});
      end
      chk("idle ones", 0, aofs_dsp_model_i.idle_ones);
      chk("sync inside", 0, aofs_dsp_model_i.sync_mid);
    end
    n = 0;
    while (link.time_sync !== 1'b1 && n < 800) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    j = 0;
    do begin
      @(posedge pclk);
      if (link.sample_tick === 1'b1) n++;
      j++;
    end while (link.time_sync !== 1'b1 && j < 800);
    chk("ts period", 128, n);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_format();
    t_divider();
    t_stream();
    end_of_test();
  end
endmodule
